/* verilog/rtcc_pkg.sv */
// Constants, types and shared decoding for the calendar, alarm and stopwatch
package rtcc_pkg;

  // Timing: pclk period and the two tick periods
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_TIME_NS = 1000000000;
  localparam int unsigned HUNDREDTH_TIME_NS = 10000000;
  localparam int unsigned SEC_CYCLES = SEC_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned HUNDREDTH_CYCLES = HUNDREDTH_TIME_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] OFS_SECONDS = 8'h00;
  localparam logic [7:0] OFS_MINUTES = 8'h04;
  localparam logic [7:0] OFS_HOURS = 8'h08;
  localparam logic [7:0] OFS_DAY = 8'h0C;
  localparam logic [7:0] OFS_MONTH = 8'h10;
  localparam logic [7:0] OFS_YEAR = 8'h14;
  localparam logic [7:0] OFS_WEEKDAY = 8'h18;
  localparam logic [7:0] OFS_ALARM_MINUTE = 8'h1C;
  localparam logic [7:0] OFS_ALARM_HOUR = 8'h20;
  localparam logic [7:0] OFS_STOPWATCH = 8'h24;
  localparam logic [7:0] OFS_CONTROL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_COMPENSATION = 8'h30;

  // Control register fields
  localparam int unsigned CTRL_MODULE_EN_BIT = 0;
  localparam int unsigned CTRL_SW_EN_BIT = 1;
  localparam int unsigned CTRL_SW_CLEAR_BIT = 2;
  localparam int unsigned CTRL_ALARM_IE_BIT = 3;
  // Status and compensation fields
  localparam int unsigned STAT_ALARM_FLAG_BIT = 0;
  localparam int unsigned COMP_UNLOCKED_BIT = 2;

  // Unlock sequence written to write_unlock_field
  localparam logic [1:0] UNLOCK_FIRST = 2'h2;
  localparam logic [1:0] UNLOCK_SECOND = 2'h1;

  // Counter limits
  localparam logic [7:0] SEC_MAX = 8'h3B;
  localparam logic [7:0] MIN_MAX = 8'h3B;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [7:0] MONTH_FIRST = 8'h01;
  localparam logic [7:0] MONTH_MAX = 8'h0C;
  localparam logic [7:0] YEAR_MIN = 8'h9D;
  localparam logic [7:0] YEAR_MAX = 8'h63;
  localparam logic [7:0] WEEKDAY_MAX = 8'h06;
  localparam logic [7:0] SW_MAX = 8'h63;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [1:0] {LOCK_SHUT, LOCK_HALF, LOCK_OPEN} rtcc_lock_type;

  // Length of the month, for the day wrap point and write checks
  function automatic logic [7:0] rtcc_month_days(input logic [7:0] month,
                                                 input logic [7:0] year);
    case (month)
      8'h02: rtcc_month_days = (year[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: rtcc_month_days = 8'h1E;
      default: rtcc_month_days = 8'h1F;
    endcase
  endfunction : rtcc_month_days

endpackage : rtcc_pkg

/* verilog/rtcc_tick_gen.sv */
// Free divider giving a one-cycle tick every DIV enabled cycles
module rtcc_tick_gen
  import rtcc_pkg::*;
#(
  parameter int unsigned DIV = HUNDREDTH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic clear,
  output logic tick
);

  typedef struct packed {
    logic [31:0] count;
  } rtcc_tick_state_type;

  localparam logic [31:0] LAST = 32'(DIV - 1);

  rtcc_tick_state_type st_reg;
  rtcc_tick_state_type st_next;

  // Stopped divider holds its phase, so a resume is not a fresh period
  assign tick = run && (st_reg.count == LAST);

  // Divider step
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.count = 32'h0000_0000;
    end else if (run) begin
      st_next.count = (st_reg.count == LAST) ? 32'h0000_0000
                                             : st_reg.count + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : rtcc_tick_gen

/* verilog/rtcc_top.sv */
// Calendar counters, hour/minute alarm and stopwatch behind an APB slave
//
// What this block does
// - Alarm flag sets when hour and minute counters equal the alarm registers.
// - Interrupt output is high while alarm flag and alarm enable are set.
// - Alarm minute stores any value; values above 59 never match.
// - Alarm hour stores any value; values above 23 never match.
// - Reads leave counters alone; valid writes load and counting continues.
// - Seconds wrap 59 to 0; writes above 59 ignored.
// - Minutes wrap 59 to 0; writes above 59 ignored.
// - Hours wrap 23 to 0; writes above 23 ignored.
// - Day wraps to 1 after month end; invalid day writes ignored.
// - Month wraps 12 to 1; writes outside 1 to 12 ignored.
// - Year is signed offset from 2000, valid -99 to +99.
// - Weekday wraps 6 to 0; writes above 6 ignored.
// - Time writes are blocked until the unlock sequence has been written.
// - Stopwatch is read-only; reset and clear bit zero it.
// - Stopwatch counts hundredths and wraps after 0x63.
// - Stopwatch ticks come from their own divider, not the second tick.
// - Status read with flag set, then alarm hour read, clears flag.
// - Clear bit zeroes stopwatch, self-clears, reads as zero.
// - Stopwatch enable low holds the stopwatch count.
// - Module enable low stops all counting, registers keep contents.
module rtcc_top
  import rtcc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES_P = SEC_CYCLES,
  parameter int unsigned HUND_CYCLES_P = HUNDREDTH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic alarm_irq
);

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] weekday;
    logic [7:0] alarm_minute;
    logic [7:0] alarm_hour;
    logic [7:0] stopwatch;
    logic module_en;
    logic sw_en;
    logic alarm_ie;
    logic alarm_flag;
    logic match_prev;
    logic status_seen;
    logic [1:0] unlock_field;
    rtcc_lock_type lock_st;
    logic [31:0] rdata;
  } rtcc_state_type;

  rtcc_state_type st_reg;
  rtcc_state_type st_next;

  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic match;
  logic match_rise;
  logic sec_tick;
  logic hund_tick;
  logic sw_clr;
  logic sec_wr;
  logic unlocked;

  // Map of decoded addresses, used by the error answer; the read mux decodes on its own
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      OFS_SECONDS, OFS_MINUTES, OFS_HOURS, OFS_DAY, OFS_MONTH, OFS_YEAR,
      OFS_WEEKDAY, OFS_ALARM_MINUTE, OFS_ALARM_HOUR, OFS_STOPWATCH,
      OFS_CONTROL, OFS_STATUS, OFS_COMPENSATION: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // APB phases; zero wait states, so every access phase completes
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = st_reg.rdata;
  assign unlocked = (st_reg.lock_st == LOCK_OPEN);
  assign sec_wr = wr_acc && (paddr == OFS_SECONDS) && unlocked &&
                  (pwdata[7:0] <= SEC_MAX);
  assign sw_clr = wr_acc && (paddr == OFS_CONTROL) &&
                  pwdata[CTRL_SW_CLEAR_BIT];

  // Out-of-range alarm values can never equal a live counter anyway
  assign match = (st_reg.alarm_minute <= MIN_MAX) &&
                 (st_reg.alarm_hour <= HOUR_MAX) &&
                 (st_reg.hour == st_reg.alarm_hour) &&
                 (st_reg.min == st_reg.alarm_minute);
  assign match_rise = match && !st_reg.match_prev;
  assign alarm_irq = st_reg.alarm_flag && st_reg.alarm_ie;

  // Fixed one-second source with no trim; an accepted seconds write restarts its phase
  rtcc_tick_gen #(
    .DIV(SEC_CYCLES_P)
  ) u_sec_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_reg.module_en),
    .clear(sec_wr),
    .tick(sec_tick)
  );

  // Separate hundredths source, so stopwatch ticks keep their own phase apart from seconds
  rtcc_tick_gen #(
    .DIV(HUND_CYCLES_P)
  ) u_hund_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_reg.module_en && st_reg.sw_en),
    .clear(sw_clr),
    .tick(hund_tick)
  );

  // Next state: counting, register writes, read side effects
  always_comb begin
    logic carry;
    logic [7:0] wbyte;
    logic [31:0] rmux;
    carry = 1'b0;
    wbyte = pwdata[7:0];
    rmux = RST_RDATA;
    st_next = st_reg;
    st_next.match_prev = match;

    // Calendar cascade, only when a second tick arrives
    if (sec_tick) begin
      if (st_reg.sec == SEC_MAX) begin
        st_next.sec = RST_ZERO;
        carry = 1'b1;
      end else begin
        st_next.sec = st_reg.sec + 8'h01;
      end
      if (carry) begin
        carry = (st_reg.min == MIN_MAX);
        st_next.min = carry ? RST_ZERO : st_reg.min + 8'h01;
      end
      if (carry) begin
        carry = (st_reg.hour == HOUR_MAX);
        st_next.hour = carry ? RST_ZERO : st_reg.hour + 8'h01;
      end
      if (carry) begin
        st_next.weekday = (st_reg.weekday == WEEKDAY_MAX) ? RST_ZERO
                          : st_reg.weekday + 8'h01;
        carry = (st_reg.day ==
                 rtcc_month_days(st_reg.month, st_reg.year));
        st_next.day = carry ? DAY_FIRST : st_reg.day + 8'h01;
      end
      if (carry) begin
        carry = (st_reg.month == MONTH_MAX);
        st_next.month = carry ? MONTH_FIRST : st_reg.month + 8'h01;
      end
      if (carry) begin
        // Wrap past +99 to -99 keeps the year in its valid range
        st_next.year = (st_reg.year == YEAR_MAX) ? YEAR_MIN
                       : st_reg.year + 8'h01;
      end
    end

    // Stopwatch, cleared or stepped on its own tick
    if (sw_clr) begin
      st_next.stopwatch = RST_ZERO;
    end else if (hund_tick) begin
      st_next.stopwatch = (st_reg.stopwatch == SW_MAX) ? RST_ZERO
                          : st_reg.stopwatch + 8'h01;
    end

    // Register writes win over a tick in the same cycle
    if (wr_acc) begin
      case (paddr)
        OFS_SECONDS: begin
          if (sec_wr) begin
            st_next.sec = wbyte;
          end
        end
        OFS_MINUTES: begin
          if (unlocked && wbyte <= MIN_MAX) begin
            st_next.min = wbyte;
          end
        end
        OFS_HOURS: begin
          if (unlocked && wbyte <= HOUR_MAX) begin
            st_next.hour = wbyte;
          end
        end
        OFS_DAY: begin
          if (unlocked && wbyte >= DAY_FIRST &&
              wbyte <= rtcc_month_days(st_reg.month, st_reg.year)) begin
            st_next.day = wbyte;
          end
        end
        OFS_MONTH: begin
          if (unlocked && wbyte >= MONTH_FIRST && wbyte <= MONTH_MAX) begin
            st_next.month = wbyte;
          end
        end
        OFS_YEAR: begin
          if (unlocked && $signed(wbyte) >= $signed(YEAR_MIN) &&
              $signed(wbyte) <= $signed(YEAR_MAX)) begin
            st_next.year = wbyte;
          end
        end
        OFS_WEEKDAY: begin
          if (unlocked && wbyte <= WEEKDAY_MAX) begin
            st_next.weekday = wbyte;
          end
        end
        OFS_ALARM_MINUTE: st_next.alarm_minute = wbyte;
        OFS_ALARM_HOUR: st_next.alarm_hour = wbyte;
        OFS_CONTROL: begin
          st_next.module_en = pwdata[CTRL_MODULE_EN_BIT];
          st_next.sw_en = pwdata[CTRL_SW_EN_BIT];
          st_next.alarm_ie = pwdata[CTRL_ALARM_IE_BIT];
        end
        OFS_COMPENSATION: begin
          st_next.unlock_field = pwdata[1:0];
          // Two-step unlock; any other value shuts the gate again
          case (st_reg.lock_st)
            LOCK_SHUT: st_next.lock_st = (pwdata[1:0] == UNLOCK_FIRST)
                                         ? LOCK_HALF : LOCK_SHUT;
            LOCK_HALF: st_next.lock_st = (pwdata[1:0] == UNLOCK_SECOND)
                                         ? LOCK_OPEN : LOCK_SHUT;
            LOCK_OPEN: st_next.lock_st = (pwdata[1:0] == UNLOCK_SECOND)
                                         ? LOCK_OPEN : LOCK_SHUT;
            default: st_next.lock_st = LOCK_SHUT;
          endcase
        end
        default: ; // Stopwatch and status are read-only
      endcase
    end

    // Alarm flag clear handshake: status read arms, alarm hour read clears
    if (rd_acc && paddr == OFS_STATUS && st_reg.alarm_flag) begin
      st_next.status_seen = 1'b1;
    end
    if (rd_acc && paddr == OFS_ALARM_HOUR && st_reg.status_seen) begin
      st_next.alarm_flag = 1'b0;
      st_next.status_seen = 1'b0;
    end
    // A new match wins over a clear in the same cycle
    if (match_rise) begin
      st_next.alarm_flag = 1'b1;
    end

    // Read data is latched in the setup phase, valid in the access phase
    case (paddr)
      OFS_SECONDS: rmux[7:0] = st_reg.sec;
      OFS_MINUTES: rmux[7:0] = st_reg.min;
      OFS_HOURS: rmux[7:0] = st_reg.hour;
      OFS_DAY: rmux[7:0] = st_reg.day;
      OFS_MONTH: rmux[7:0] = st_reg.month;
      OFS_YEAR: rmux[7:0] = st_reg.year;
      OFS_WEEKDAY: rmux[7:0] = st_reg.weekday;
      OFS_ALARM_MINUTE: rmux[7:0] = st_reg.alarm_minute;
      OFS_ALARM_HOUR: rmux[7:0] = st_reg.alarm_hour;
      OFS_STOPWATCH: rmux[7:0] = st_reg.stopwatch;
      OFS_CONTROL: begin
        rmux[CTRL_MODULE_EN_BIT] = st_reg.module_en;
        rmux[CTRL_SW_EN_BIT] = st_reg.sw_en;
        rmux[CTRL_ALARM_IE_BIT] = st_reg.alarm_ie; // Clear bit reads 0
      end
      OFS_STATUS: rmux[STAT_ALARM_FLAG_BIT] = st_reg.alarm_flag;
      OFS_COMPENSATION: begin
        rmux[1:0] = st_reg.unlock_field;
        rmux[COMP_UNLOCKED_BIT] = unlocked;
      end
      default: rmux = RST_RDATA;
    endcase
    if (setup && !pwrite) begin
      st_next.rdata = rmux;
    end
  end

  // State register; match_prev starts high so reset alarm 00:00 stays quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{sec: RST_ZERO, min: RST_ZERO, hour: RST_ZERO,
                  day: RST_DAY, month: RST_MONTH, year: RST_ZERO,
                  weekday: RST_ZERO, alarm_minute: RST_ZERO,
                  alarm_hour: RST_ZERO, stopwatch: RST_ZERO,
                  module_en: 1'b0, sw_en: 1'b0, alarm_ie: 1'b0,
                  alarm_flag: 1'b0, match_prev: 1'b1, status_seen: 1'b0,
                  unlock_field: 2'h0, lock_st: LOCK_SHUT, rdata: RST_RDATA};
    end else begin
      st_reg <= st_next;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence status_arm_s;
    rd_acc && paddr == OFS_STATUS && st_reg.alarm_flag;
  endsequence
  sequence hour_read_s;
    rd_acc && paddr == OFS_ALARM_HOUR && !match_rise;
  endsequence

  alarm_set_a: assert property (match_rise |=> st_reg.alarm_flag)
    else $error("alarm flag missed a match");
  alarm_irq_a: assert property (
    match_rise && st_reg.alarm_ie && !wr_acc |=> alarm_irq)
    else $error("interrupt not raised with flag and enable");
  // Hour read may follow back to back or after one idle bus cycle
  alarm_clear_a: assert property (
    status_arm_s ##[2:3] hour_read_s |=> !st_reg.alarm_flag)
    else $error("alarm flag not cleared by read pair");
  sec_wrap_a: assert property (
    sec_tick && st_reg.sec == SEC_MAX && !wr_acc |=>
    st_reg.sec == RST_ZERO && $changed(st_reg.min))
    else $error("seconds did not wrap and carry");
  hour_write_a: assert property (
    wr_acc && paddr == OFS_HOURS && pwdata[7:0] > HOUR_MAX && !sec_tick
    |=> $stable(st_reg.hour))
    else $error("invalid hour write took effect");
  locked_write_a: assert property (
    wr_acc && paddr == OFS_MINUTES && !unlocked && !sec_tick
    |=> $stable(st_reg.min))
    else $error("minute write passed while locked");
  sw_clear_a: assert property (
    sw_clr |=> st_reg.stopwatch == RST_ZERO ##1
    (st_reg.stopwatch == RST_ZERO)[*2])
    else $error("stopwatch clear failed");
  sw_wrap_a: assert property (
    hund_tick && !sw_clr && st_reg.stopwatch == SW_MAX
    |=> st_reg.stopwatch == RST_ZERO)
    else $error("stopwatch did not wrap after 0x63");
  sw_hold_a: assert property (
    !st_reg.sw_en && !sw_clr |=> $stable(st_reg.stopwatch))
    else $error("stopwatch moved while disabled");
  disable_hold_a: assert property (
    !st_reg.module_en && !wr_acc [*2] |=> $stable(st_reg.sec) &&
    $stable(st_reg.stopwatch))
    else $error("counter moved while module disabled");

endmodule : rtcc_top

/* bench/rtcc_top_bench.sv */
// Self-checking bench for the calendar, alarm and stopwatch block
module rtcc_top_bench
  import rtcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short divider counts keep the run brief
  localparam int unsigned SECP = 20;
  localparam int unsigned HUNDP = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alarm_irq;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int m_sec, m_min, m_hour, m_day, m_mon, m_year, m_wday;
  logic [31:0] rd;
  logic err;
  logic [7:0] v;
  logic [31:0] ie;
  logic flag;
  // Range table: address, accepted value, refused value
  logic [7:0] rg_a [9] = '{OFS_SECONDS, OFS_MINUTES, OFS_HOURS, OFS_WEEKDAY,
    OFS_MONTH, OFS_MONTH, OFS_YEAR, OFS_MONTH, OFS_DAY};
  logic [7:0] rg_g [9] = '{8'h3B, 8'h3B, 8'h17, 8'h06, 8'h0C, 8'h01, 8'h9D,
    8'h04, 8'h1E};
  logic [7:0] rg_b [9] = '{8'h3C, 8'h3C, 8'h18, 8'h07, 8'h0D, 8'h00, 8'h9C,
    8'h00, 8'h1F};
  // Rollover cases: month, year, day, alarm minute, alarm hour
  int rl_mon [4] = '{2, 2, 12, 2};
  int rl_yr [4] = '{1, 4, 99, -4};
  int rl_day [4] = '{28, 28, 31, 28};
  logic [7:0] rl_am [4] = '{8'h00, 8'h3C, 8'h00, 8'h00};
  logic [7:0] rl_ah [4] = '{8'h00, 8'h00, 8'h00, 8'h18};

  rtcc_top #(.SEC_CYCLES_P(SECP), .HUND_CYCLES_P(HUNDP)) dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .alarm_irq(alarm_irq)
  );

  // Free-running bus clock
  always #5 pclk = ~pclk;

  // Watchdog, well above the expected run length
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [32:0] exp,
                       input logic [32:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Read and compare, error response included
  task automatic rdc(input string name, input logic [7:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, {1'b0, exp}, {err, rd});
  endtask : rdc

  function automatic int mdays(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction : mdays

  // Reference calendar, one second step
  task automatic mtick();
    if (++m_sec < 60) return;
    m_sec = 0;
    if (++m_min < 60) return;
    m_min = 0;
    if (++m_hour < 24) return;
    m_hour = 0;
    m_wday = (m_wday + 1) % 7;
    if (++m_day <= mdays(m_mon, m_year)) return;
    m_day = 1;
    if (++m_mon <= 12) return;
    m_mon = 1;
    m_year = (m_year == 99) ? -99 : m_year + 1;
  endtask : mtick

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    m_sec = 0;
    m_min = 0;
    m_hour = 0;
    m_day = 1;
    m_mon = 1;
    m_year = 0;
    m_wday = 0;
  endtask : do_reset

  task automatic cmp_time();
    rdc("seconds", OFS_SECONDS, m_sec);
    rdc("minutes", OFS_MINUTES, m_min);
    rdc("hours", OFS_HOURS, m_hour);
    rdc("day", OFS_DAY, m_day);
    rdc("month", OFS_MONTH, m_mon);
    rdc("year", OFS_YEAR, {24'h0, 8'(m_year)});
    rdc("weekday", OFS_WEEKDAY, m_wday);
  endtask : cmp_time

  // Month and year first, since day is checked against them
  task automatic set_time(input int mo, input int yr, input int dy);
    m_mon = mo;
    m_year = yr;
    m_day = dy;
    m_hour = 23;
    m_min = 59;
    m_sec = 58;
    m_wday = 6;
    wr(OFS_MONTH, m_mon);
    wr(OFS_YEAR, {24'h0, 8'(m_year)});
    wr(OFS_DAY, m_day);
    wr(OFS_HOURS, m_hour);
    wr(OFS_MINUTES, m_min);
    wr(OFS_SECONDS, m_sec);
    wr(OFS_WEEKDAY, m_wday);
  endtask : set_time

  // Main sequence
  initial begin
    void'($urandom(32'hCC84F39E));
    do_reset();
    cmp_time();
    rdc("stopwatch", OFS_STOPWATCH, 0);
    rdc("status", OFS_STATUS, 0);
    // Locked, a wrong key, half open, then the real unlock
    wr(OFS_SECONDS, 5);
    wr(OFS_MINUTES, 5);
    rdc("locked", OFS_SECONDS, 0);
    rdc("locked_min", OFS_MINUTES, 0);
    wr(OFS_COMPENSATION, UNLOCK_SECOND);
    wr(OFS_SECONDS, 5);
    rdc("wrong_key", OFS_SECONDS, 0);
    wr(OFS_COMPENSATION, UNLOCK_FIRST);
    wr(OFS_SECONDS, 5);
    rdc("half", OFS_SECONDS, 0);
    wr(OFS_COMPENSATION, UNLOCK_SECOND);
    rdc("unlock", OFS_COMPENSATION, 32'h5);
    // Boundary values accepted, one past refused, then random seconds above 59 refused
    for (int i = 0; i < 9; i++) begin
      wr(rg_a[i], rg_g[i]);
      wr(rg_a[i], rg_b[i]);
      rdc("range", rg_a[i], rg_g[i]);
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom % 60);
      wr(OFS_SECONDS, v);
      wr(OFS_SECONDS, 8'(60 + $urandom % 196));
      rdc("random", OFS_SECONDS, v);
    end
    // Midnight carries, leap years, alarm match and its clearing
    for (int i = 0; i < 4; i++) begin
      set_time(rl_mon[i], rl_yr[i], rl_day[i]);
      wr(OFS_ALARM_MINUTE, rl_am[i]);
      wr(OFS_ALARM_HOUR, rl_ah[i]);
      rdc("alarm_minute", OFS_ALARM_MINUTE, rl_am[i]);
      ie = (i != 2) ? 32'h8 : 32'h0;
      // Run about 2.5 s so exactly two second ticks land
      wr(OFS_CONTROL, ie | 32'h1);
      repeat (48) @(posedge pclk);
      wr(OFS_CONTROL, ie);
      mtick();
      mtick();
      cmp_time();
      flag = (rl_am[i] == 8'h00 && rl_ah[i] == 8'h00);
      #1;
      check("alarm_irq", flag && i != 2, alarm_irq);
      rdc("status", OFS_STATUS, flag);
      rdc("alarm_hour", OFS_ALARM_HOUR, rl_ah[i]);
      rdc("status", OFS_STATUS, 0);
      #1;
      check("alarm_irq", 0, alarm_irq);
    end
    // Disabled module keeps every calendar count
    repeat (60) @(posedge pclk);
    cmp_time();
    // Stopwatch: read-only, clear, count, hold, wrap
    wr(OFS_STOPWATCH, 5);
    rdc("sw_ro", OFS_STOPWATCH, 0);
    wr(OFS_CONTROL, 32'h4);
    rdc("control", OFS_CONTROL, 0);
    wr(OFS_CONTROL, 32'h3);
    repeat (48) @(posedge pclk);
    wr(OFS_CONTROL, 32'h1);
    rdc("sw_count", OFS_STOPWATCH, 6);
    repeat (40) @(posedge pclk);
    rdc("sw_hold", OFS_STOPWATCH, 6);
    wr(OFS_CONTROL, 32'h4);
    wr(OFS_CONTROL, 32'h3);
    repeat (818) @(posedge pclk);
    wr(OFS_CONTROL, 32'h1);
    rdc("sw_wrap", OFS_STOPWATCH, 2);
    wr(OFS_CONTROL, 32'h5);
    rdc("sw_clear", OFS_STOPWATCH, 0);
    // Second reset in mid-run with the stopwatch counting
    wr(OFS_CONTROL, 32'h3);
    repeat (30) @(posedge pclk);
    do_reset();
    rdc("sw_reset", OFS_STOPWATCH, 0);
    cmp_time();
    // Unmapped address answers with an error and zero data
    apb(1'b0, 8'h40, 32'h0000_0000);
    check("unmapped", {1'b1, 32'h0}, {err, rd});
    apb(1'b1, 8'h40, 32'h0000_00FF);
    check("unmapped_wr", 1'b1, err);
    report_and_stop();
  end

endmodule : rtcc_top_bench
